/* mct_counter_timer.sv */
// Multichannel counter/timer control with AXI4-Lite registers.
// Assumes one 10 MHz clock; pins are asynchronous and synchronised here.
`timescale 1ns/10ps
module mct_counter_timer #(
   parameter int unsigned NCH = 8,
   parameter int unsigned DEPTH = 56000,
   parameter int unsigned SHORT_CYC = mct_pkg::RST_SHORT_CYC,
   parameter int unsigned LONG_CYC = mct_pkg::RST_LONG_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NCH-1:0] countIn,
   input wire logic startIn,
   input wire logic stopIn,
   input wire logic gateIn,
   input wire logic resetBtn_n,
   output logic runOut,
   output logic gateLed,
   output mct_pkg::mct_disp_type dispUpper,
   output mct_pkg::mct_disp_type dispLower,
   output logic sysResetReq,
   output logic fwUpdateMode
);
   import mct_pkg::*;

   localparam int unsigned MEMW = DEPTH * (NCH + 1);
   localparam int unsigned MAW = $clog2(MEMW);

   if (NCH < 8 || NCH > 64 || DEPTH < 1)
      $error("NCH must be 8..64 and DEPTH at least 1");

   typedef struct packed {
      logic awRdy;
      logic awHeld;
      logic [7:0] awAddr;
      logic wRdy;
      logic wHeld;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic arRdy;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [1:0] mode;
      logic [3:0] inv;
      logic [TMR_W-1:0] tPre;
      logic [31:0] cPre;
      logic [3:0] dispSel;
      logic [1:0] snapCtl;
      logic [31:0] onTime;
      logic [31:0] offTime;
      logic [5:0] chanSel;
      logic [MAW-1:0] snapAddr;
      logic running;
      logic limitHit;
      logic [7:0] usDiv;
      logic [TMR_W-1:0] timer;
      logic [NCH-1:0][31:0] cnt;
      logic clkPhase;
      logic [31:0] phaseCnt;
      logic busy;
      logic [6:0] idx;
      logic [NCH:0][31:0] shadow;
      logic [MAW-1:0] wAddr;
      logic [31:0] snapCnt;
      logic full;
      logic runPin;
      logic led;
   } mct_state_type;

   mct_state_type s_q, s_d;
   logic [31:0] snapMem [MEMW];
   logic [31:0] memRd_q;
   logic [NCH-1:0] chRise;
   logic [2:0] ctlLvl;
   logic [2:0] ctlRise;
   logic [2:0] ctlFall;
   logic btnReset;

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            r[8*b +: 8] = nw[8*b +: 8];
      return r;
   endfunction : mergeStrb

   function automatic logic [31:0] clampLow(input logic [31:0] v);
      return (v == 32'h0) ? 32'h1 : v;
   endfunction : clampLow

   function automatic mct_state_type rstState();
      mct_state_type r;
      r = '0;
      r.tPre = TMR_W'(1);
      r.cPre = 32'h1;
      r.onTime = 32'h1;
      r.offTime = 32'h1;
      r.dispSel = {DISP_TIMER, DISP_COUNT};
      return r;
   endfunction : rstState

   mct_in_sync #(.W(3)) u_ctl_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pinIn({gateIn, stopIn, startIn}),
      .inv(s_q.inv[2:0]),
      .lvl(ctlLvl),
      .rise(ctlRise),
      .fall(ctlFall)
   );

   mct_in_sync #(.W(NCH)) u_ch_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pinIn(countIn),
      .inv('0),
      .lvl(),
      .rise(chRise),
      .fall()
   );

   mct_reset_button #(.SHORT_CYC(SHORT_CYC), .LONG_CYC(LONG_CYC)) u_btn (
      .clk(clk),
      .rst_n(rst_n),
      .btnPin_n(resetBtn_n),
      .sysResetReq(btnReset),
      .fwUpdateMode(fwUpdateMode)
   );

   assign sysResetReq = btnReset;
   assign s_axi_awready = s_q.awRdy;
   assign s_axi_wready = s_q.wRdy;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_arready = s_q.arRdy;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign runOut = s_q.runPin;
   assign gateLed = s_q.led;
   assign dispUpper = mct_disp_type'(s_q.dispSel[1:0]);
   assign dispLower = mct_disp_type'(s_q.dispSel[3:2]);

   always_comb
   begin
      logic [31:0] wv;
      logic [31:0] rv;
      logic [7:0] wa;
      logic [7:0] ra;
      logic softStart;
      logic softStop;
      logic clear;
      logic snapClr;
      logic tick;
      logic active;
      logic limSel;
      logic clkTrig;
      logic trig;
      logic [31:0] phaseEnd;
      logic [TMR_W-1:0] tv;
      wv = '0;
      rv = '0;
      wa = {s_q.awAddr[7:2], 2'h0};
      ra = {s_axi_araddr[7:2], 2'h0};
      softStart = 1'b0;
      softStop = 1'b0;
      clear = 1'b0;
      snapClr = 1'b0;
      clkTrig = 1'b0;
      trig = 1'b0;
      tv = '0;
      // Microsecond tick for timer and internal snapshot clock
      tick = (s_q.usDiv == 8'(TICK_CYC - 1));
      limSel = (s_q.mode == STOP_TIMER) || (s_q.mode == STOP_COUNT);
      active = s_q.running && ctlLvl[2] && (!s_q.snapCtl[SNAP_CLK] || s_q.clkPhase);
      phaseEnd = s_q.clkPhase ? s_q.onTime : s_q.offTime;
      s_d = s_q;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && s_q.awRdy)
      begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wRdy)
      begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata;
         s_d.wStrb = s_axi_wstrb;
      end
      if (s_q.bValid && s_axi_bready)
         s_d.bValid = 1'b0;
      if (s_q.awHeld && s_q.wHeld && !s_q.bValid)
      begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = RESP_OKAY;
         case (wa)
            REG_CTRL:
            begin
               wv = mergeStrb({20'h0, s_q.inv, 2'h0, s_q.mode, 4'h0}, s_q.wData, s_q.wStrb);
               softStart = wv[CTRL_START];
               softStop = wv[CTRL_STOP];
               clear = wv[CTRL_CLEAR];
               snapClr = wv[CTRL_SNAP_CLR];
               s_d.mode = wv[CTRL_MODE_LSB +: 2];
               s_d.inv = wv[CTRL_INV_LSB +: 4];
            end
            REG_TPRE_LO, REG_TPRE_HI:
            begin
               if (wa == REG_TPRE_LO)
               begin
                  wv = mergeStrb(s_q.tPre[31:0], s_q.wData, s_q.wStrb);
                  tv = {s_q.tPre[TMR_W-1:32], wv};
               end
               else
               begin
                  wv = mergeStrb(32'(s_q.tPre[TMR_W-1:32]), s_q.wData, s_q.wStrb);
                  tv = {wv[TMR_W-33:0], s_q.tPre[31:0]};
               end
               if (tv == '0)
                  tv = TMR_W'(1);
               if (tv > TMR_W'(TMR_MAX_US))
                  tv = TMR_W'(TMR_MAX_US);
               s_d.tPre = tv;
            end
            REG_CPRE:
            begin
               wv = clampLow(mergeStrb(s_q.cPre, s_q.wData, s_q.wStrb));
               s_d.cPre = (wv > 32'(CNT_MAX)) ? 32'(CNT_MAX) : wv;
            end
            REG_DISP:
               s_d.dispSel = s_q.wData[3:0];
            REG_SNAP_CTL:
               s_d.snapCtl = s_q.wData[1:0];
            REG_ON_TIME:
               s_d.onTime = clampLow(mergeStrb(s_q.onTime, s_q.wData, s_q.wStrb));
            REG_OFF_TIME:
               s_d.offTime = clampLow(mergeStrb(s_q.offTime, s_q.wData, s_q.wStrb));
            REG_CHAN_SEL:
               s_d.chanSel = s_q.wData[5:0];
            REG_SNAP_ADDR:
            begin
               wv = s_q.wData;
               s_d.snapAddr = (wv >= MEMW) ? MAW'(MEMW - 1) : wv[MAW-1:0];
            end
            REG_STATUS, REG_TMR_LO, REG_TMR_HI, REG_SNAP_CNT, REG_CHAN_DATA,
            REG_SNAP_DATA:
               s_d.bResp = RESP_OKAY;
            default:
               s_d.bResp = RESP_SLVERR;
         endcase
      end
      s_d.awRdy = !s_d.awHeld;
      s_d.wRdy = !s_d.wHeld;

      // Read channel: data is captured at the address edge
      if (s_q.rValid && s_axi_rready)
         s_d.rValid = 1'b0;
      if (s_axi_arvalid && s_q.arRdy)
      begin
         s_d.rValid = 1'b1;
         s_d.rResp = RESP_OKAY;
         case (ra)
            REG_CTRL:
               rv = {20'h0, s_q.inv, 2'h0, s_q.mode, 4'h0};
            REG_STATUS:
               rv = {26'h0, s_q.full, s_q.busy, ctlLvl[2], s_q.limitHit, s_q.led,
                  s_q.running};
            REG_TPRE_LO:
               rv = s_q.tPre[31:0];
            REG_TPRE_HI:
               rv = 32'(s_q.tPre[TMR_W-1:32]);
            REG_TMR_LO:
               rv = s_q.timer[31:0];
            REG_TMR_HI:
               rv = 32'(s_q.timer[TMR_W-1:32]);
            REG_CPRE:
               rv = s_q.cPre;
            REG_DISP:
               rv = {28'h0, s_q.dispSel};
            REG_SNAP_CTL:
               rv = {30'h0, s_q.snapCtl};
            REG_ON_TIME:
               rv = s_q.onTime;
            REG_OFF_TIME:
               rv = s_q.offTime;
            REG_SNAP_CNT:
               rv = s_q.snapCnt;
            REG_CHAN_SEL:
               rv = {26'h0, s_q.chanSel};
            REG_CHAN_DATA:
               rv = (s_q.chanSel < NCH) ? s_q.cnt[s_q.chanSel] : 32'h0;
            REG_SNAP_ADDR:
               rv = 32'(s_q.snapAddr);
            REG_SNAP_DATA:
               rv = memRd_q;
            default:
               s_d.rResp = RESP_SLVERR;
         endcase
         s_d.rData = rv;
      end
      s_d.arRdy = !s_d.rValid;

      s_d.usDiv = tick ? 8'h0 : s_q.usDiv + 8'h1;

      if (clear)
      begin
         s_d.cnt = '0;
         s_d.timer = '0;
         s_d.limitHit = 1'b0;
      end
      if ((ctlRise[0] || softStart) && !(limSel && s_q.limitHit))
         s_d.running = 1'b1;
      if (ctlRise[1] || softStop)
         s_d.running = 1'b0;

      if (active && !clear)
      begin
         for (int i = 0; i < NCH; i++)
            if (chRise[i])
               s_d.cnt[i] = s_q.cnt[i] + 32'h1;
         if (tick)
            s_d.timer = s_q.timer + TMR_W'(1);
      end

      // auto stop at timer limit, or at count limit on channel 7 only
      if (s_d.running &&
         ((s_q.mode == STOP_TIMER && s_d.timer >= s_q.tPre) ||
         (s_q.mode == STOP_COUNT && s_d.cnt[LIMIT_CH] >= s_q.cPre)))
      begin
         s_d.running = 1'b0;
         s_d.limitHit = 1'b1;
      end

      // Internal snapshot clock starts in its on phase at each run
      if (s_q.snapCtl[SNAP_CLK] && s_q.running)
      begin
         if (tick)
         begin
            if (s_q.phaseCnt + 32'h1 >= phaseEnd)
            begin
               s_d.clkPhase = !s_q.clkPhase;
               s_d.phaseCnt = '0;
               clkTrig = 1'b1;
            end
            else
               s_d.phaseCnt = s_q.phaseCnt + 32'h1;
         end
      end
      else
      begin
         s_d.clkPhase = 1'b1;
         s_d.phaseCnt = '0;
      end

      // snapshot triggers; a trigger during a write is dropped
      trig = (s_q.snapCtl[SNAP_GATE] && s_q.running && (ctlRise[2] || ctlFall[2])) ||
         (s_q.snapCtl[SNAP_CLK] && clkTrig);
      if (s_q.busy)
      begin
         s_d.wAddr = s_q.wAddr + MAW'(1);
         s_d.idx = s_q.idx + 7'h1;
         if (s_q.idx == 7'(NCH))
         begin
            s_d.busy = 1'b0;
            s_d.snapCnt = s_q.snapCnt + 32'h1;
            s_d.full = (s_q.snapCnt + 32'h1 == DEPTH);
         end
      end
      else if (trig && !s_q.full)
      begin
         s_d.busy = 1'b1;
         s_d.idx = '0;
         s_d.shadow = {s_q.timer[31:0], s_q.cnt};
      end
      if (snapClr && !s_q.busy)
      begin
         s_d.wAddr = '0;
         s_d.snapCnt = '0;
         s_d.full = 1'b0;
      end

      s_d.runPin = active ^ s_q.inv[INV_RUN];
      s_d.led = active;
   end

   // button reset acts as power-up reset
   always_ff @(posedge clk)
   begin
      if (!rst_n || btnReset)
         s_q <= rstState();
      else
         s_q <= s_d;
   end

   // Snapshot storage: one word per channel, timer word last
   always_ff @(posedge clk)
   begin
      if (s_q.busy)
         snapMem[s_q.wAddr] <= s_q.shadow[s_q.idx];
      memRd_q <= snapMem[s_q.snapAddr];
   end
endmodule : mct_counter_timer

/* mct_pkg.sv */
// Constants shared by the counter/timer control block and its helpers.
// Assumes a single 10 MHz clock and a 32-bit AXI4-Lite register bus.
package mct_pkg;
   localparam int unsigned CLK_HZ = 10_000_000;
   // Timer resolution and reset-button press thresholds
   localparam int unsigned TICK_TIME_US = 1;
   localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_TIME_US;
   localparam int unsigned RST_SHORT_MS = 1000;
   localparam int unsigned RST_LONG_MS = 3000;
   localparam int unsigned RST_SHORT_CYC = CLK_HZ / 1000 * RST_SHORT_MS;
   localparam int unsigned RST_LONG_CYC = CLK_HZ / 1000 * RST_LONG_MS;
   // Preset limits: timer in microseconds, count preset in counts
   localparam int unsigned TMR_W = 40;
   localparam longint TMR_MAX_S = 1_000_000;
   localparam longint TMR_MAX_US = TMR_MAX_S * 1_000_000;
   localparam longint CNT_MAX_KCTS = 4_294_967;
   localparam longint CNT_MAX = CNT_MAX_KCTS * 1000;
   localparam int unsigned LIMIT_CH = 7;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TPRE_LO = 8'h08;
   localparam logic [7:0] REG_TPRE_HI = 8'h0c;
   localparam logic [7:0] REG_TMR_LO = 8'h10;
   localparam logic [7:0] REG_TMR_HI = 8'h14;
   localparam logic [7:0] REG_CPRE = 8'h18;
   localparam logic [7:0] REG_DISP = 8'h1c;
   localparam logic [7:0] REG_SNAP_CTL = 8'h20;
   localparam logic [7:0] REG_ON_TIME = 8'h24;
   localparam logic [7:0] REG_OFF_TIME = 8'h28;
   localparam logic [7:0] REG_SNAP_CNT = 8'h2c;
   localparam logic [7:0] REG_CHAN_SEL = 8'h30;
   localparam logic [7:0] REG_CHAN_DATA = 8'h34;
   localparam logic [7:0] REG_SNAP_ADDR = 8'h38;
   localparam logic [7:0] REG_SNAP_DATA = 8'h3c;
   // CTRL fields: write-one pulses in 3:0, stop mode 5:4, inversions 11:8
   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_STOP = 1;
   localparam int unsigned CTRL_CLEAR = 2;
   localparam int unsigned CTRL_SNAP_CLR = 3;
   localparam int unsigned CTRL_MODE_LSB = 4;
   localparam int unsigned CTRL_INV_LSB = 8;
   // Inversion bit order within the 4-bit field
   localparam int unsigned INV_START = 0;
   localparam int unsigned INV_STOP = 1;
   localparam int unsigned INV_GATE = 2;
   localparam int unsigned INV_RUN = 3;
   localparam int unsigned SNAP_GATE = 0;
   localparam int unsigned SNAP_CLK = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {STOP_NONE, STOP_TIMER, STOP_COUNT} mct_stop_type;
   typedef enum logic [1:0] {DISP_COUNT, DISP_TIMER, DISP_CPRE, DISP_TPRE} mct_disp_type;
endpackage : mct_pkg

/* mct_in_sync.sv */
// Two-stage synchroniser with polarity select and edge detection.
// Assumes asynchronous pin inputs; inv comes from the clk domain.
`timescale 1ns/10ps
module mct_in_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pinIn,
   input wire logic [W-1:0] inv,
   output logic [W-1:0] lvl,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
   } mct_sync_type;
   mct_sync_type s_q, s_d;

   // Changing inv flips lvl and may show one spurious edge
   assign lvl = s_q.sync ^ inv;
   assign rise = lvl & ~s_q.prev;
   assign fall = ~lvl & s_q.prev;

   always_comb
   begin
      s_d = s_q;
      s_d.meta = pinIn;
      s_d.sync = s_q.meta;
      s_d.prev = lvl;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : mct_in_sync

/* mct_reset_button.sv */
// Front reset button timer: short press resets, long press enters update mode.
// Assumes an active-low asynchronous button pin; debouncing is by duration.
`timescale 1ns/10ps
module mct_reset_button #(
   parameter int unsigned SHORT_CYC = 10,
   parameter int unsigned LONG_CYC = 30
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic btnPin_n,
   output logic sysResetReq,
   output logic fwUpdateMode
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic [31:0] held;
      logic rstPulse;
      logic fwMode;
   } mct_btn_type;
   mct_btn_type s_q, s_d;

   assign sysResetReq = s_q.rstPulse;
   assign fwUpdateMode = s_q.fwMode;

   always_comb
   begin
      s_d = s_q;
      s_d.meta = ~btnPin_n;
      s_d.sync = s_q.meta;
      s_d.prev = s_q.sync;
      s_d.rstPulse = 1'b0;
      if (s_q.sync && s_q.held < LONG_CYC)
         s_d.held = s_q.held + 32'h1;
      if (s_q.sync && s_q.held >= LONG_CYC)
         s_d.fwMode = 1'b1;
      if (!s_q.sync)
      begin
         s_d.held = '0;
         if (s_q.prev && s_q.held < SHORT_CYC)
            s_d.rstPulse = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : mct_reset_button

/* mct_counter_timer_properties.sv */
// Port-level checker for the counter/timer control block.
// Assumes polarity bits for stop and gate stay at their reset value.
`timescale 1ns/10ps
module mct_ct_properties
   import mct_pkg::*;
#(
   parameter int unsigned LONG_CYC = 60
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic stopIn,
   input wire logic gateIn,
   input wire logic resetBtn_n,
   input wire logic runOut,
   input wire logic gateLed,
   input wire mct_pkg::mct_disp_type dispUpper,
   input wire mct_pkg::mct_disp_type dispLower,
   input wire logic sysResetReq,
   input wire logic fwUpdateMode
);
   int pressCnt;
   // Length of the current button press, for the press-time rules
   always_ff @(posedge clk) pressCnt <= (!rst_n || resetBtn_n) ? 0 : pressCnt + 1;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_reset_idle:
      assert property (disable iff (1'b0) !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && !runOut
         && !gateLed && dispUpper == DISP_COUNT && dispLower == DISP_TIMER)
      else $error("outputs not idle after reset");
   a_bresp_hold:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_read_answer:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_write_answer:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_stop_ends:
      assert property ($rose(stopIn) && gateLed |-> ##[1:6] !gateLed)
      else $error("stop edge did not end counting");
   a_gate_pause:
      assert property ($fell(gateIn) && gateLed |-> ##[1:6] !gateLed)
      else $error("gate low did not pause counting");
   a_fw_long:
      assert property (pressCnt == LONG_CYC + 5 |-> fwUpdateMode)
      else $error("long press did not enter update mode");
   a_fw_early:
      assert property ($rose(fwUpdateMode) |-> pressCnt >= LONG_CYC)
      else $error("update mode entered too soon");
   a_sysrst_pulse:
      assert property (sysResetReq |=> !sysResetReq && !fwUpdateMode)
      else $error("reset request not a single pulse");
endmodule : mct_ct_properties

bind mct_counter_timer mct_ct_properties #(.LONG_CYC(LONG_CYC)) i_mct_ct_properties (.*);

/* mct_ext_source.sv */
// Model of the external start, stop, gate and count sources.
// Assumes the caller runs one task at a time; pins change after rising edges.
`timescale 1ns/10ps
module mct_ext_source #(
   parameter int unsigned NCH = 8
) (
   input wire logic clk,
   output logic startIn,
   output logic stopIn,
   output logic gateIn,
   output logic [NCH-1:0] countIn
);
   initial
   begin
      startIn = 1'b0;
      stopIn = 1'b0;
      gateIn = 1'b1;
      countIn = '0;
   end
   // pulses two clocks wide, then settle
   task automatic pulse(input logic [NCH+1:0] m, input int n);
      repeat (n)
      begin
         @(posedge clk);
         {stopIn, startIn, countIn} <= m;
         repeat (2) @(posedge clk);
         {stopIn, startIn, countIn} <= '0;
         repeat (2) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic setGate(input logic v);
      @(posedge clk);
      gateIn <= v;
      repeat (5) @(posedge clk);
   endtask : setGate
endmodule : mct_ext_source

/* mct_counter_timer_tb.sv */
// Self-checking bench for the counter/timer control block.
// Assumes shortened button thresholds; registers reached over AXI4-Lite.
`timescale 1ns/10ps
module mct_counter_timer_tb;
   import mct_pkg::*;
   localparam int unsigned NCH = 8;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, resetBtn_n = 1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic runOut, gateLed, sysResetReq, fwUpdateMode, startIn, stopIn, gateIn;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [NCH-1:0] countIn;
   mct_disp_type dispUpper, dispLower;
   int err_count = 0, compares = 0;
   int n;
   initial
   begin
      forever #50 clk = ~clk;
   end
   mct_counter_timer #(.NCH(NCH), .DEPTH(4), .SHORT_CYC(20), .LONG_CYC(60))
      i_mct_counter_timer (.*);
   mct_ext_source #(.NCH(NCH)) i_mct_ext_source (.*);
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic tmo(input string nm);
      err_count++;
      $display("mismatch %s expected answer seen timeout", nm);
      conclude();
   endtask : tmo
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      // One edge between calls so bready is never assigned twice in a step
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 40) tmo("bvalid");
      chk("bresp", er, s_axi_bresp);
   endtask : axiWrite
   task automatic axiRead(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      int k;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 40) tmo("rvalid");
      chk("rdata", exp, s_axi_rdata);
      chk("rresp", er, s_axi_rresp);
   endtask : axiRead
   task automatic waitLed(input logic v, input int lim);
      int k;
      for (k = 0; k < lim && gateLed !== v; k++)
         @(posedge clk);
      if (k == lim) tmo("gateLed");
   endtask : waitLed
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("dispUpper", DISP_COUNT, dispUpper);
      chk("dispLower", DISP_TIMER, dispLower);
      axiRead(REG_CTRL, 0, RESP_OKAY);
      axiRead(8'h40, 0, RESP_SLVERR);
      axiWrite(8'h40, 32'h1, RESP_SLVERR);
      axiWrite(REG_CPRE, 0, RESP_OKAY);
      axiRead(REG_CPRE, 1, RESP_OKAY);
      axiWrite(REG_CPRE, 32'hffffffff, RESP_OKAY);
      axiRead(REG_CPRE, 32'(CNT_MAX), RESP_OKAY);
      axiWrite(REG_TPRE_LO, 32'hffffffff, RESP_OKAY);
      axiWrite(REG_TPRE_HI, 32'hff, RESP_OKAY);
      axiRead(REG_TPRE_HI, 32'he8, RESP_OKAY);
      axiRead(REG_TPRE_LO, 32'hd4a51000, RESP_OKAY);
      $display("test registers done");
      axiWrite(REG_SNAP_CTL, 1, RESP_OKAY);
      axiWrite(REG_CTRL, 32'h4, RESP_OKAY);
      i_mct_ext_source.pulse(10'h100, 1);
      waitLed(1, 10);
      chk("runOut", 1, runOut);
      i_mct_ext_source.pulse(10'h0ff, 4);
      i_mct_ext_source.setGate(0);
      chk("gateLed", 0, gateLed);
      i_mct_ext_source.pulse(10'h0ff, 3);
      i_mct_ext_source.setGate(1);
      i_mct_ext_source.pulse(10'h0ff, 1);
      i_mct_ext_source.pulse(10'h200, 1);
      waitLed(0, 10);
      axiWrite(REG_CHAN_SEL, 5, RESP_OKAY);
      axiRead(REG_CHAN_DATA, 5, RESP_OKAY);
      // Gate fall and rise in the run each store one snapshot of NCH+1 words
      axiRead(REG_SNAP_CNT, 2, RESP_OKAY);
      axiWrite(REG_SNAP_ADDR, NCH + 1 + 5, RESP_OKAY);
      axiRead(REG_SNAP_DATA, 4, RESP_OKAY);
      $display("test start stop gate done");
      axiWrite(REG_CPRE, 3, RESP_OKAY);
      axiWrite(REG_CTRL, 32'h24, RESP_OKAY);
      i_mct_ext_source.pulse(10'h100, 1);
      waitLed(1, 10);
      i_mct_ext_source.pulse(10'h001, 5);
      chk("gateLed", 1, gateLed);
      i_mct_ext_source.pulse(10'h080, 3);
      chk("gateLed", 0, gateLed);
      i_mct_ext_source.pulse(10'h100, 1);
      chk("gateLed", 0, gateLed);
      axiRead(REG_STATUS, 32'hc, RESP_OKAY);
      $display("test count limit done");
      axiWrite(REG_TPRE_LO, 20, RESP_OKAY);
      axiWrite(REG_TPRE_HI, 0, RESP_OKAY);
      axiWrite(REG_CTRL, 32'h14, RESP_OKAY);
      i_mct_ext_source.pulse(10'h100, 1);
      waitLed(1, 10);
      waitLed(0, 20 * TICK_CYC + 20);
      axiRead(REG_TMR_LO, 20, RESP_OKAY);
      i_mct_ext_source.pulse(10'h100, 1);
      chk("gateLed", 0, gateLed);
      $display("test timer limit done");
      axiWrite(REG_CTRL, 32'h800, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk("runOut", 1, runOut);
      resetBtn_n <= 1'b0;
      repeat (10) @(posedge clk);
      resetBtn_n <= 1'b1;
      for (n = 0; n < 20 && sysResetReq !== 1'b1; n++)
         @(posedge clk);
      chk("sysResetReq", 1, sysResetReq);
      repeat (4) @(posedge clk);
      chk("runOut", 0, runOut);
      axiRead(REG_CTRL, 0, RESP_OKAY);
      resetBtn_n <= 1'b0;
      repeat (70) @(posedge clk);
      chk("fwUpdateMode", 1, fwUpdateMode);
      resetBtn_n <= 1'b1;
      $display("test polarity and button done");
      conclude();
   end
endmodule : mct_counter_timer_tb
